// [design/ttr_regs.v]
// Test and tuning register bank of a two-channel sensor transceiver.
// Assumes a decoded word register port and synchronous pin-side inputs.
// Register accesses are one-cycle strobes with a word index; reads return
// one cycle later. Mid and long blanking and the FLL delay are parameters so a bench may shorten them.
// Outputs feed the analogue front end and the two frame decoders directly.
// Oscillator-domain users take only static settings from this block.
`timescale 1ns/1ps
`include "ttr_defs.vh"
module ttr_regs #(
    parameter [23:0] BLANK_MID_CYC = `TTR_BLANK_MID_MS * 1000 * `TTR_CLK_MHZ,
    parameter [23:0] BLANK_LONG_CYC = `TTR_BLANK_LONG_MS * 1000 * `TTR_CLK_MHZ,
    parameter [23:0] FLL_DELAY_CYC = `TTR_FLL_DELAY_MS * 1000 * `TTR_CLK_MHZ
) (
    // Clock and reset
    input wire clk_i,
    input wire rstn_i,

    // Register port
    input wire [5:0] reg_addr_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [15:0] reg_wdata_i,
    output reg [15:0] reg_rdata_o,

    // Serial output CRC path
    input wire crc_lsb_i,
    output wire crc_lsb_o,

    // Digital test pins
    output reg digital_out_ch1_o,
    output reg digital_out_ch2_o,

    // Slot selection, 0..5 for slots 1..6
    input wire [2:0] slot_i,
    output wire [2:0] cfg_slot_o,
    output wire [2:0] data_slot_o,
    output wire force_empty_o,

    // Data buffer read event
    input wire buf_rd_i,
    output wire buf_reload_o,
    output wire [9:0] buf_empty_val_o,

    // Coupling test
    input wire cct_done_i,
    output reg cct_run_o,
    output reg cct_master_o,

    // Analog receiver controls
    input wire short_gnd_i,
    output wire ch1_off_o,
    output wire thr_fixed_o,
    output wire [3:0] thr_level_o,
    output wire track_fast_o,
    output wire base_track_hold_o,
    input wire start_bits_i,
    input wire baud_fast_i,
    output wire [5:0] filter_osc_cyc_o,

    // Startup blanking
    input wire sensor_start_i,
    output wire blank_o,

    // FLL reset
    input wire err_i,
    output reg fll_rst_o,

    // Decoder options, index 0 channel 1, index 1 channel 2
    output wire [1:0] slow_err_en_o,
    output wire [1:0] period_meas_en_o,
    output wire [1:0] duty_chk_en_o,
    output wire [1:0] start_err_clr_o,

    // Sync skew
    input wire auto_sync_both_i,
    input wire sync1_i,
    output reg sync2_o
);

    // Times in system clock cycles; 128 us fits 16 bits, a skew step is
    // widened to the skew counter so the product needs no padding
    localparam [15:0] SHORT_CYC = `TTR_BLANK_SHORT_US * `TTR_CLK_MHZ;
    localparam [18:0] SKEW_STEP = `TTR_SKEW_STEP_US * `TTR_CLK_MHZ;
    // Blanking selector codes; 00 and 11 both give the short time
    localparam [1:0] BLK_MID = 2'h1;
    localparam [1:0] BLK_LONG = 2'h2;
    // One-hot FLL reset sequencer
    localparam [2:0] F_IDLE = 3'h1;
    localparam [2:0] F_WAIT = 3'h2;
    localparam [2:0] F_PULSE = 3'h4;

    reg [1:0] rst_sync_reg;
    wire rst_n;
    // Register images, one per index
    reg [15:0] sts_reg;
    reg [15:0] selftest_runtime_ctrl_reg;
    reg [15:0] adv1_reg;
    reg [15:0] adv2_reg;
    // Timers and sequencer state
    reg [23:0] blank_cnt_reg;
    reg [23:0] fll_cnt_reg;
    reg [2:0] fll_state_reg;
    reg [2:0] fll_state_next;
    reg [18:0] skew_cnt_reg;
    reg skew_busy_reg;
    reg grounded_reg;
    reg [23:0] blank_len;
    // Write strobe of the run-time register; the coupling test acts on the
    // written word, as start and abort are commands rather than settings
    wire wr_selftest_runtime_ctrl;
    genvar ch;
    assign wr_selftest_runtime_ctrl = reg_wr_i && (reg_addr_i == `TTR_ADDR_SELFTEST_RUNTIME_CTRL);

    // Reset released through two flops
    // Assertion stays asynchronous; release never races a clock edge
    // in the register and timer flops that use the copy
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i)
            rst_sync_reg <= 2'h0;
        else
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
    assign rst_n = rst_sync_reg[1];

    // Slot pair partner: flips the pair member
    // Pairs 1-2, 3-4 and 5-6 are indices 0-1, 2-3 and 4-5
    function [2:0] ttr_partner;
        input [2:0] s;
        begin
            ttr_partner = {s[2:1], ~s[0]};
        end
    endfunction

    // Register writes; reserved bits masked to their defaults
    // Masking at write time keeps reserved bits at their reset value, so a
    // read never needs a second mask and the outputs never see them
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            sts_reg <= `TTR_RST_STS;
            selftest_runtime_ctrl_reg <= `TTR_RST_SELFTEST_RUNTIME_CTRL;
            adv1_reg <= `TTR_RST_ADV1;
            adv2_reg <= `TTR_RST_ADV2;
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                `TTR_ADDR_STS: sts_reg <= reg_wdata_i & `TTR_MASK_STS;
                // Abort is a command, not stored, so it reads back zero
                `TTR_ADDR_SELFTEST_RUNTIME_CTRL: selftest_runtime_ctrl_reg <= reg_wdata_i & `TTR_MASK_SELFTEST_RUNTIME_CTRL
                    & ~(16'h0001 << `TTR_BIT_ABORT);
                `TTR_ADDR_ADV1: adv1_reg <= (reg_wdata_i & `TTR_MASK_ADV1)
                    | (`TTR_RST_ADV1 & ~`TTR_MASK_ADV1);
                `TTR_ADDR_ADV2: adv2_reg <= reg_wdata_i & `TTR_MASK_ADV2;
                // Writes to any other index are dropped
                default: sts_reg <= sts_reg;
            endcase
        end
    end

    // Read data registered; unmapped addresses read zero
    // Data stands until the next read strobe, so the host may take it late
    // without a hold register of its own
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n)
            reg_rdata_o <= 16'h0000;
        else if (reg_rd_i) begin
            case (reg_addr_i)
                `TTR_ADDR_STS: reg_rdata_o <= sts_reg;
                `TTR_ADDR_SELFTEST_RUNTIME_CTRL: reg_rdata_o <= selftest_runtime_ctrl_reg;
                `TTR_ADDR_ADV1: reg_rdata_o <= adv1_reg;
                `TTR_ADDR_ADV2: reg_rdata_o <= adv2_reg;
                default: reg_rdata_o <= 16'h0000;
            endcase
        end
    end

    // CRC and test pins
    // The inversion is combinational so it lands on the bit being shifted
    // out; test pins are registered to keep glitches off the package pins
    assign crc_lsb_o = crc_lsb_i ^ sts_reg[`TTR_BIT_FCRC];
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            digital_out_ch1_o <= 1'b0;
            digital_out_ch2_o <= 1'b0;
        end else begin
            // Unselected pin keeps its last level; other codes change nothing
            case (sts_reg[`TTR_SEL_HI:`TTR_SEL_LO])
                `TTR_SEL_CH1: digital_out_ch1_o <= sts_reg[`TTR_BIT_TPLVL];
                `TTR_SEL_CH2: digital_out_ch2_o <= sts_reg[`TTR_BIT_TPLVL];
                default: digital_out_ch1_o <= digital_out_ch1_o;
            endcase
        end
    end

    // Slot multiplexers
    // Swap and shift are independent and may be set together; shift acts
    // on data, swap on the selector of ID, check type and bit count
    assign cfg_slot_o = selftest_runtime_ctrl_reg[`TTR_BIT_SWAP] ? ttr_partner(slot_i) : slot_i;
    // Odd slots (index even) take the next even slot's data
    assign data_slot_o = (selftest_runtime_ctrl_reg[`TTR_BIT_SHIFT] && !slot_i[0]) ?
        ttr_partner(slot_i) : slot_i;
    assign force_empty_o = selftest_runtime_ctrl_reg[`TTR_BIT_SHIFT] && !slot_i[0];

    // Buffer reload after read
    // The buffer owner writes the marker; this block only says when
    assign buf_reload_o = buf_rd_i && !selftest_runtime_ctrl_reg[`TTR_BIT_KEEP];
    assign buf_empty_val_o = `TTR_EMPTY;

    // Coupling test; abort wins over a start in the same write
    // A start during a run keeps cct_run_o high and only switches the mode; the engine's done
    // pulse ends a run, but a start in that same cycle still wins
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            cct_run_o <= 1'b0;
            cct_master_o <= 1'b0;
        end else if (wr_selftest_runtime_ctrl && reg_wdata_i[`TTR_BIT_ABORT]) begin
            cct_run_o <= 1'b0;
        end else if (wr_selftest_runtime_ctrl
                     && (reg_wdata_i[`TTR_CCT_HI:`TTR_CCT_LO] == `TTR_CCT_MASTER
                     || reg_wdata_i[`TTR_CCT_HI:`TTR_CCT_LO] == `TTR_CCT_SLAVE)) begin
            cct_run_o <= 1'b1;
            cct_master_o <= reg_wdata_i[`TTR_CCT_LO];
        end else if (cct_done_i) begin
            cct_run_o <= 1'b0;
        end
    end

    // Short to ground latches channel off unless masked
    // The short input is already filtered; the latch keeps the channel off
    // after the short goes away, until software sets the mask
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n)
            grounded_reg <= 1'b0;
        else if (adv1_reg[`TTR_BIT_GMASK])
            grounded_reg <= 1'b0;
        else if (short_gnd_i)
            grounded_reg <= 1'b1;
    end
    assign ch1_off_o = grounded_reg;

    // Threshold and tracking controls
    // The level code only matters while the fixed mode bit is set
    assign thr_fixed_o = adv1_reg[`TTR_BIT_FIXTH];
    assign thr_level_o = adv1_reg[`TTR_LVL_HI:`TTR_LVL_LO];
    assign track_fast_o = adv1_reg[`TTR_BIT_TRACK];
    assign base_track_hold_o = start_bits_i && !adv1_reg[`TTR_BIT_UNFRZ];
    // Filter length in 16 MHz periods, counted by the oscillator domain
    // Settings are static between frames, so no handshake is needed there;
    // the largest sum is 15 + 24, which fits the six-bit count
    assign filter_osc_cyc_o = {2'h0, adv1_reg[`TTR_FLT_HI:`TTR_FLT_LO]} +
        (baud_fast_i ? 6'd`TTR_FLT_BASE_FAST : 6'd`TTR_FLT_BASE_SLOW);

    // Startup blanking timer
    // A new start reloads the timer even mid-blank; a selector change
    // mid-blank takes effect only at the next start
    always @* begin
        case (adv1_reg[`TTR_BLK_HI:`TTR_BLK_LO])
            BLK_MID: blank_len = BLANK_MID_CYC;
            BLK_LONG: blank_len = BLANK_LONG_CYC;
            default: blank_len = {8'h00, SHORT_CYC};
        endcase
    end
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n)
            blank_cnt_reg <= 24'h000000;
        else if (sensor_start_i)
            blank_cnt_reg <= blank_len;
        else if (blank_cnt_reg != 24'h000000)
            blank_cnt_reg <= blank_cnt_reg - 24'h000001;
    end
    assign blank_o = blank_cnt_reg != 24'h000000;

    // FLL reset after error, immediate or delayed
    // The counter reloads while idle so every error gets the full delay;
    // errors during a wait are absorbed, giving one reset per episode
    always @* begin
        case (fll_state_reg)
            F_IDLE: fll_state_next = err_i ?
                (adv2_reg[`TTR_BIT_FLLD] ? F_WAIT : F_PULSE) : F_IDLE;
            F_WAIT: fll_state_next = (fll_cnt_reg == 24'h000001) ? F_PULSE : F_WAIT;
            F_PULSE: fll_state_next = F_IDLE;
            default: fll_state_next = F_IDLE;
        endcase
    end
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            fll_state_reg <= F_IDLE;
            fll_cnt_reg <= 24'h000000;
            fll_rst_o <= 1'b0;
        end else begin
            fll_state_reg <= fll_state_next;
            fll_rst_o <= (fll_state_next == F_PULSE);
            if (fll_state_reg == F_IDLE)
                fll_cnt_reg <= FLL_DELAY_CYC;
            else if (fll_cnt_reg != 24'h000000)
                fll_cnt_reg <= fll_cnt_reg - 24'h000001;
        end
    end

    // Per-channel decoder options; channel 2 fields sit one stride above
    // those of channel 1, so one lane body serves both
    generate
        for (ch = 0; ch < 2; ch = ch + 1) begin : g_dec_opt
            // Disable bits are stored as such, so flip them into enables
            assign slow_err_en_o[ch] = adv2_reg[`TTR_BIT_SLOW1 + ch * `TTR_CH_STRIDE];
            assign period_meas_en_o[ch] = ~adv2_reg[`TTR_BIT_PMOFF1 + ch * `TTR_CH_STRIDE];
            assign duty_chk_en_o[ch] = ~adv2_reg[`TTR_BIT_DCOFF1 + ch * `TTR_CH_STRIDE];
            assign start_err_clr_o[ch] = adv2_reg[`TTR_BIT_SECLR1 + ch * `TTR_CH_STRIDE];
        end
    endgenerate

    // Channel 2 sync delay; zero skew or manual sync passes through
    // A sync pulse during a wait restarts it and the earlier one is lost;
    // the pulse fires at count two as the output flop adds the last cycle
    // Seven steps of the skew at most, well within the 19-bit counter
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            skew_cnt_reg <= 19'h00000;
            skew_busy_reg <= 1'b0;
            sync2_o <= 1'b0;
        end else begin
            sync2_o <= 1'b0;
            if (sync1_i && (!auto_sync_both_i ||
                adv2_reg[`TTR_SKEW_HI:`TTR_SKEW_LO] == 3'h0)) begin
                sync2_o <= 1'b1;
            end else if (sync1_i) begin
                skew_busy_reg <= 1'b1;
                skew_cnt_reg <= adv2_reg[`TTR_SKEW_HI:`TTR_SKEW_LO] * SKEW_STEP;
            end else if (skew_busy_reg) begin
                if (skew_cnt_reg <= 19'h00002) begin
                    skew_busy_reg <= 1'b0;
                    sync2_o <= 1'b1;
                end
                skew_cnt_reg <= skew_cnt_reg - 19'h00001;
            end
        end
    end

endmodule // ttr_regs

// [design/ttr_defs.vh]
// Constants for the test and tuning register bank.
// Assumes a 250 MHz system clock and a simple word register port.
`ifndef TTR_DEFS_VH
`define TTR_DEFS_VH
`define TTR_ADDR_STS 6'h2C
`define TTR_ADDR_SELFTEST_RUNTIME_CTRL 6'h2D
`define TTR_ADDR_ADV1 6'h2E
`define TTR_ADDR_ADV2 6'h2F
`define TTR_RST_STS 16'h0000
`define TTR_RST_SELFTEST_RUNTIME_CTRL 16'h0000
`define TTR_RST_ADV1 16'h4400
`define TTR_RST_ADV2 16'h0000
`define TTR_MASK_STS 16'h87E0
`define TTR_MASK_SELFTEST_RUNTIME_CTRL 16'h6039
`define TTR_MASK_ADV1 16'hFBFD
`define TTR_MASK_ADV2 16'h9E7F
`define TTR_BIT_FCRC 15
`define TTR_BIT_TPLVL 10
`define TTR_SEL_HI 9
`define TTR_SEL_LO 5
`define TTR_SEL_CH1 5'h15
`define TTR_SEL_CH2 5'h16
`define TTR_BIT_SWAP 14
`define TTR_BIT_SHIFT 13
`define TTR_BIT_ABORT 5
`define TTR_CCT_HI 4
`define TTR_CCT_LO 3
`define TTR_CCT_MASTER 2'h1
`define TTR_CCT_SLAVE 2'h2
`define TTR_BIT_KEEP 0
`define TTR_BIT_GMASK 15
`define TTR_LVL_HI 14
`define TTR_LVL_LO 11
`define TTR_BIT_TRACK 9
`define TTR_BLK_HI 8
`define TTR_BLK_LO 7
`define TTR_FLT_HI 6
`define TTR_FLT_LO 3
`define TTR_BIT_UNFRZ 2
`define TTR_BIT_FIXTH 0
`define TTR_BIT_FLLD 15
`define TTR_BIT_SLOW2 12
`define TTR_BIT_PMOFF2 11
`define TTR_BIT_DCOFF2 10
`define TTR_BIT_SECLR2 9
`define TTR_BIT_SLOW1 6
`define TTR_BIT_PMOFF1 5
`define TTR_BIT_DCOFF1 4
`define TTR_BIT_SECLR1 3
`define TTR_SKEW_HI 2
`define TTR_SKEW_LO 0
`define TTR_CH_STRIDE 6
`define TTR_EMPTY 10'h1F0
// Times in their own units and the clock rate
`define TTR_CLK_MHZ 250
`define TTR_BLANK_SHORT_US 128
`define TTR_BLANK_MID_MS 5
`define TTR_BLANK_LONG_MS 10
`define TTR_FLL_DELAY_MS 20
`define TTR_SKEW_STEP_US 2
`define TTR_OSC_MHZ 16
`define TTR_FLT_BASE_FAST 16
`define TTR_FLT_BASE_SLOW 24
`endif

// [bench/ttr_far_model.sv]
// Far-side model of the cross-coupling test engine.
// Assumes a test runs while run_i is high and ends on a done pulse.
`timescale 1ns/1ps
module ttr_far_model #(
    parameter int RUN_CYC = 20
) (
    // Clock and reset
    input wire clk_i,
    input wire rstn_i,
    // Test handshake
    input wire run_i,
    output logic done_o
);
    int cnt;
    // Ends a test after a fixed time; a new run restarts the count
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt <= 0;
            done_o <= 1'b0;
        end else begin
            done_o <= run_i && cnt == RUN_CYC - 1;
            cnt <= (run_i && !done_o) ? cnt + 1 : 0;
        end
    end
endmodule // ttr_far_model

// [bench/ttr_regs_checker.sv]
// Port-level checks for the test and tuning register bank.
// Assumes it is bound to ttr_regs and sees only its ports.
`timescale 1ns/1ps
module ttr_regs_checker (
    // Clock, reset and register port
    input wire clk_i,
    input wire rstn_i,
    input wire [5:0] reg_addr_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [15:0] reg_wdata_i,
    input wire [15:0] reg_rdata_o,
    // Outputs and their causes
    input wire crc_lsb_i,
    input wire crc_lsb_o,
    input wire [2:0] slot_i,
    input wire force_empty_o,
    input wire buf_rd_i,
    input wire buf_reload_o,
    input wire err_i,
    input wire fll_rst_o,
    input wire cct_run_o,
    input wire cct_master_o,
    input wire thr_fixed_o,
    input wire [3:0] thr_level_o,
    input wire [1:0] slow_err_en_o,
    input wire sync2_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    // Write decodes, one per register
    wire w_sts = reg_wr_i && reg_addr_i == 6'h2C;
    wire w_selftest_runtime_ctrl = reg_wr_i && reg_addr_i == 6'h2D;
    wire w_adv1 = reg_wr_i && reg_addr_i == 6'h2E;
    wire w_adv2 = reg_wr_i && reg_addr_i == 6'h2F;
    a_crc_flip: assert property (w_sts |=> crc_lsb_o == (crc_lsb_i ^ $past(reg_wdata_i[15])))
        else $error("crc lsb wrong");
    a_empty_odd: assert property (w_selftest_runtime_ctrl |=> force_empty_o ==
        ($past(reg_wdata_i[13]) && !slot_i[0])) else $error("empty flag wrong");
    a_reload_read: assert property (w_selftest_runtime_ctrl |=> buf_reload_o ==
        (buf_rd_i && !$past(reg_wdata_i[0]))) else $error("reload wrong");
    a_cct_master: assert property (w_selftest_runtime_ctrl && reg_wdata_i[5:3] == 3'h1 |=> cct_run_o && cct_master_o)
        else $error("master start missing");
    a_cct_abort: assert property (w_selftest_runtime_ctrl && reg_wdata_i[5] |=> !cct_run_o)
        else $error("abort ignored");
    a_fll_prompt: assert property (w_adv2 && !reg_wdata_i[15] ##2 err_i |=> fll_rst_o)
        else $error("fll reset late");
    a_level_code: assert property (w_adv1 |=> thr_level_o == $past(reg_wdata_i[14:11])
        && thr_fixed_o == $past(reg_wdata_i[0])) else $error("threshold wrong");
    a_slow_enable: assert property (w_adv2 |=> slow_err_en_o ==
        {$past(reg_wdata_i[12]), $past(reg_wdata_i[6])}) else $error("slow enable wrong");
    a_unmapped_zero: assert property (reg_rd_i && (reg_addr_i < 6'h2C || reg_addr_i > 6'h2F)
        |=> reg_rdata_o == 16'h0000) else $error("unmapped read not zero");
    // Main scenarios reached
    c_cct: cover property ($rose(cct_run_o));
    c_fll: cover property (fll_rst_o);
    c_sync: cover property (sync2_o);
endmodule // ttr_regs_checker

// [bench/testbench.sv]
// Self-checking bench for the test and tuning register bank.
// Assumes ttr_regs, its checker and the far-side model are compiled.
`timescale 1ns/1ps
module testbench;
    logic clk, rstn, wen, ren, crc_i, brd, sg, stb, fast, ss, err, auto, sy1;
    logic [5:0] addr;
    logic [15:0] wd;
    logic [2:0] slot;
    wire [15:0] rdata;
    wire crc_o, d1, d2, fe, rel, run, mst, off, fixd, trk, hold, blank, fll, sy2, done;
    wire [2:0] cs, ds;
    wire [9:0] ev;
    wire [3:0] lvl;
    wire [5:0] flt;
    wire [1:0] se, pe, de, sc;
    int n_fail, compares, cycles;
    int bl[4] = '{32000, 50, 100, 32000};
    // Short counts keep the run brief
    ttr_regs #(.BLANK_MID_CYC(24'h32), .BLANK_LONG_CYC(24'h64), .FLL_DELAY_CYC(24'h28)) dut (
        .clk_i(clk), .rstn_i(rstn), .reg_addr_i(addr), .reg_wr_i(wen), .reg_rd_i(ren),
        .reg_wdata_i(wd), .reg_rdata_o(rdata), .crc_lsb_i(crc_i), .crc_lsb_o(crc_o),
        .digital_out_ch1_o(d1), .digital_out_ch2_o(d2), .slot_i(slot), .cfg_slot_o(cs),
        .data_slot_o(ds), .force_empty_o(fe), .buf_rd_i(brd), .buf_reload_o(rel),
        .buf_empty_val_o(ev), .cct_done_i(done), .cct_run_o(run), .cct_master_o(mst),
        .short_gnd_i(sg), .ch1_off_o(off), .thr_fixed_o(fixd), .thr_level_o(lvl),
        .track_fast_o(trk), .base_track_hold_o(hold), .start_bits_i(stb), .baud_fast_i(fast),
        .filter_osc_cyc_o(flt), .sensor_start_i(ss), .blank_o(blank), .err_i(err),
        .fll_rst_o(fll), .slow_err_en_o(se), .period_meas_en_o(pe), .duty_chk_en_o(de),
        .start_err_clr_o(sc), .auto_sync_both_i(auto), .sync1_i(sy1), .sync2_o(sy2));
    ttr_far_model far (.clk_i(clk), .rstn_i(rstn), .run_i(run), .done_o(done));
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        compares++;
        if (s !== e) begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    // Strobe dropped a cycle early so no signal is set twice in one step
    task automatic wreg(input logic [5:0] a, input logic [15:0] d);
        addr = a;
        wd = d;
        wen = 1;
        cyc(1);
        wen = 0;
        cyc(1);
    endtask
    task automatic rreg(input logic [5:0] a, input logic [15:0] e);
        addr = a;
        ren = 1;
        cyc(1);
        ren = 0;
        chk(rdata, e);
        cyc(1);
    endtask
    function automatic logic sel(input int k);
        sel = (k == 0) ? blank : (k == 1) ? fll : sy2;
    endfunction
    // Cycles a signal keeps its level, allowing two cycles of slack
    task automatic tw(input int k, input logic pol, input int e);
        int n;
        n = 1;
        while (sel(k) === pol && n < 40000) begin
            cyc(1);
            n++;
        end
        chk(16'(n >= e - 2 && n <= e + 2), 16'h0001);
    endtask
    task automatic stop_test;
        $display("Comparisons %0d, mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        clk = 0;
        forever #2 clk = ~clk;
    end
    // Hang guard well above the longest blanking walk
    always @(posedge clk) begin
        cycles++;
        if (cycles == 80000) begin
            n_fail++;
            stop_test;
        end
    end
    initial begin
        {rstn, wen, ren, crc_i, brd, sg, stb, fast, ss, err, auto, sy1} = '0;
        addr = 6'h00;
        wd = 16'h0000;
        slot = 3'h0;
        repeat (8) @(posedge clk);
        #1 rstn = 1;
        cyc(3);
        // Reset values, reserved bits and an unmapped place
        rreg(6'h2C, 16'h0000);
        rreg(6'h2D, 16'h0000);
        rreg(6'h2E, 16'h4400);
        rreg(6'h2F, 16'h0000);
        for (int a = 'h2C; a < 'h30; a++) wreg(6'(a), 16'hFFFF);
        rreg(6'h2C, 16'h87E0);
        rreg(6'h2D, 16'h6019);
        rreg(6'h2E, 16'hFFFD);
        rreg(6'h2F, 16'h9E7F);
        rreg(6'h30, 16'h0000);
        // Forced CRC inversion
        wreg(6'h2C, 16'h8000);
        chk(crc_o, 1'b1);
        crc_i = 1;
        cyc(1);
        chk(crc_o, 1'b0);
        wreg(6'h2C, 16'h0000);
        chk(crc_o, 1'b1);
        // Test pins: two valid codes, one ignored
        wreg(6'h2C, 16'h06A0);
        chk({d2, d1}, 16'h0001);
        wreg(6'h2C, 16'h06C0);
        chk({d2, d1}, 16'h0003);
        wreg(6'h2C, 16'h0280);
        chk({d2, d1}, 16'h0003);
        wreg(6'h2C, 16'h02A0);
        chk({d2, d1}, 16'h0002);
        // Slot swap, then slot shift with empty odd buffers
        wreg(6'h2D, 16'h4000);
        for (int s = 0; s < 6; s++) begin
            slot = 3'(s);
            cyc(1);
            chk({9'h0, fe, ds, cs}, {10'h0, 3'(s), 3'(s ^ 1)});
        end
        wreg(6'h2D, 16'h2000);
        for (int s = 0; s < 6; s++) begin
            slot = 3'(s);
            cyc(1);
            chk({9'h0, fe, ds, cs}, {9'h0, 1'(~s), 3'(s | 1), 3'(s)});
        end
        // Buffer reload on read
        wreg(6'h2D, 16'h0000);
        brd = 1;
        cyc(1);
        chk({5'h0, rel, ev}, 16'h05F0);
        wreg(6'h2D, 16'h0001);
        chk(rel, 1'b0);
        brd = 0;
        // Coupling test codes and abort
        wreg(6'h2D, 16'h0018);
        chk(run, 1'b0);
        wreg(6'h2D, 16'h0008);
        chk({run, mst}, 16'h0003);
        wreg(6'h2D, 16'h0020);
        chk(run, 1'b0);
        wreg(6'h2D, 16'h0010);
        chk({run, mst}, 16'h0002);
        wreg(6'h2D, 16'h0018);
        chk(run, 1'b1);
        cyc(25);
        chk(run, 1'b0);
        wreg(6'h2D, 16'h0010);
        wreg(6'h2D, 16'h0028);
        chk(run, 1'b0);
        // Receiver tuning fields
        fast = 1;
        stb = 1;
        wreg(6'h2E, 16'h7A4D);
        chk({3'h0, fixd, trk, hold, lvl, flt}, {6'h06, 4'hF, 6'h19});
        fast = 0;
        cyc(1);
        chk(flt, 6'h21);
        wreg(6'h2E, 16'h0400);
        chk({3'h0, fixd, trk, hold, lvl, flt}, {6'h01, 4'h0, 6'h18});
        // Short to ground, unmasked then masked
        sg = 1;
        cyc(2);
        chk(off, 1'b1);
        wreg(6'h2E, 16'h8000);
        cyc(2);
        chk(off, 1'b0);
        sg = 0;
        // Decoder options per channel
        wreg(6'h2F, 16'h1218);
        chk({8'h0, se, pe, de, sc}, 16'h00BB);
        wreg(6'h2F, 16'h0C60);
        chk({8'h0, se, pe, de, sc}, 16'h0044);
        // FLL reset, prompt and delayed
        wreg(6'h2F, 16'h0000);
        err = 1;
        cyc(1);
        err = 0;
        tw(1, 1'b0, 1);
        wreg(6'h2F, 16'h8000);
        err = 1;
        cyc(1);
        err = 0;
        tw(1, 1'b0, 40);
        // Sync skew: 3 counts of 500 cycles, then cases with no delay
        for (int k = 0; k < 3; k++) begin
            auto = (k != 1);
            wreg(6'h2F, (k == 2) ? 16'h0000 : 16'h0003);
            sy1 = 1;
            cyc(1);
            sy1 = 0;
            tw(2, 1'b0, (k == 0) ? 1500 : 1);
        end
        // Startup blanking for each code
        for (int k = 0; k < 4; k++) begin
            wreg(6'h2E, 16'(k << 7));
            ss = 1;
            cyc(1);
            ss = 0;
            tw(0, 1'b1, bl[k]);
        end
        stop_test;
    end
endmodule // testbench
bind ttr_regs ttr_regs_checker u_chk (.clk_i, .rstn_i, .reg_addr_i, .reg_wr_i, .reg_rd_i,
    .reg_wdata_i, .reg_rdata_o, .crc_lsb_i, .crc_lsb_o, .slot_i, .force_empty_o, .buf_rd_i,
    .buf_reload_o, .err_i, .fll_rst_o, .cct_run_o, .cct_master_o, .thr_fixed_o,
    .thr_level_o, .slow_err_en_o, .sync2_o);
